// ==== bench/pipu_peer.sv ====
// far-side model: peripheral sources, external pins and core status
`timescale 1ns/1ns
`default_nettype none
module pipu_peer (
  input  wire logic       clk_i,          // core clock
  output logic      [6:0] flags_one_o,    // first group flags
  output logic      [7:1] flags_two_o,    // second group flags
  output logic      [2:0] pins_o,         // external pins 2..0
  output logic            low_power_o,    // core in idle or sleep
  output logic            reset_instr_o   // reset instruction executed
);
  // pins idle low, no source pending, core awake
  initial begin
    flags_one_o = 7'h00;
    flags_two_o = 7'h00;
    pins_o = 3'h0;
    low_power_o = 1'b0;
    reset_instr_o = 1'b0;
  end
  // peripheral flag levels and core sleep state
  task automatic drive(input logic [6:0] f1, input logic [6:0] f2, input logic lp);
    @(posedge clk_i);
    flags_one_o <= f1;
    flags_two_o <= f2;
    low_power_o <= lp;
  endtask
  // one pin to a new level, held until the flag has been set (2 sync + detect)
  task automatic pin(input int n, input logic lvl);
    @(posedge clk_i);
    pins_o[n] <= lvl;
    repeat (3) @(posedge clk_i);
  endtask
  // one-cycle pulse as the core executes the reset instruction
  task automatic instr_pulse();
    @(posedge clk_i);
    reset_instr_o <= 1'b1;
    @(posedge clk_i);
    reset_instr_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench of the interrupt priority unit
`timescale 1ns/1ns
`default_nettype none
`include "pipu_map.svh"
module tb;
  import pipu_pkg::*;
  logic        clk, resetn, rd_s, wr_s, wt, irq_h, irq_l, wake, wake_br, sbor, tmo, pdn, lp, ri;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  be;
  logic [6:0]  fl1;
  logic [7:1]  fl2;
  logic [2:0]  pins;
  logic [31:0] exp_q[$], msk_q[$];
  int          n_errors, check_count;
  logic [5:0]  ofs[6] = '{`PIPU_OFS_PEN1, `PIPU_OFS_PEN2, `PIPU_OFS_PPRI1, `PIPU_OFS_PPRI2,
                          `PIPU_OFS_CTL2, `PIPU_OFS_CTL3};
  logic [7:0]  rstv[6] = '{8'h00, 8'h00, 8'h7F, 8'hFE, 8'h74, 8'hC0};
  logic [7:0]  wmsk[4] = '{8'h7F, 8'hFE, 8'h7F, 8'hFE};

  pipu_top dut (.clk_i(clk), .resetn_i(resetn), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .periph_flags_one_i(fl1), .periph_flags_two_i(fl2),
    .ext_irq_zero_i(pins[0]), .ext_irq_one_i(pins[1]), .ext_irq_two_i(pins[2]), .low_power_i(lp),
    .reset_instr_i(ri), .timeout_flag_i(tmo), .powerdown_flag_i(pdn),
    .brownout_config_field_i(PIPU_BOR_SOFT), .irq_high_o(irq_h), .irq_low_o(irq_l), .wake_o(wake),
    .wake_branch_o(wake_br), .soft_brownout_enable_o(sbor));
  pipu_peer peer (.clk_i(clk), .flags_one_o(fl1), .flags_two_o(fl2), .pins_o(pins),
    .low_power_o(lp), .reset_instr_o(ri));

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic err(input string m, input logic [31:0] g, input logic [31:0] e);
    n_errors++;
    $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) err("read data", g, e);
  endtask
  task automatic chk(input logic g, input logic e);
    check_count++;
    if (g !== e) err("output level", {31'h0, g}, {31'h0, e});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  // one avalon-mm access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    adr <= a;
    wr_s <= w;
    rd_s <= !w;
    wdat <= d;
    be <= b;
    @(posedge clk);
    while (wt !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= 50) err("no answer", 32'h0, 32'h0);
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    bus(1'b1, a, {24'h0, v}, 4'h1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({24'h0, e & m});
    msk_q.push_back({24'h0, m});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic lv(input logic h, input logic l);
    repeat (5) @(posedge clk);
    chk(irq_h, h);
    chk(irq_l, l);
  endtask
  task automatic wchk(input logic [5:0] a, input logic [7:0] v, input logic h, input logic l);
    wr(a, v);
    lv(h, l);
  endtask

  // read data monitor: oldest note against each answered read
  always @(posedge clk) begin
    if (rd_s === 1'b1 && wt === 1'b0 && exp_q.size() > 0) cmp_rd(rdat & msk_q.pop_front(), exp_q.pop_front());
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end

  // main sequence
  initial begin
    logic [7:0] v;
    int i;
    adr = 6'h00;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wdat = 32'h0;
    be = 4'h0;
    resetn = 1'b0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'h6773_2fe3));
    tmo = 1'($urandom);
    pdn = 1'($urandom);
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i++) rd(ofs[i], rstv[i], 8'hFF);
    rd(`PIPU_OFS_RCTL, {4'h5, tmo, pdn, 2'b00}, 8'hFC);
    chk(sbor, 1'b1);
    fin("reset");
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(ofs[i], v);
      bus(1'b1, ofs[i], 32'h0000_00FF, 4'h0);
      rd(ofs[i], v & wmsk[i], 8'hFF);
    end
    wr(6'h3C, 8'hFF);
    rd(6'h3C, 8'h00, 8'hFF);
    peer.instr_pulse();
    rd(`PIPU_OFS_RCTL, 8'h00, 8'h10);
    wr(`PIPU_OFS_RCTL, 8'hF0);
    rd(`PIPU_OFS_RCTL, 8'hD0, 8'hF0);
    wr(`PIPU_OFS_RCTL, 8'h10);
    fin("registers");
    wr(`PIPU_OFS_PEN1, 8'h01);
    wr(`PIPU_OFS_PEN2, 8'h80);
    wr(`PIPU_OFS_PPRI1, 8'h00);
    wr(`PIPU_OFS_PPRI2, 8'h00);
    peer.drive(7'h01, 7'h40, 1'b0);
    wchk(`PIPU_OFS_CTL1, 8'h80, 1'b0, 1'b0);
    wchk(`PIPU_OFS_CTL1, 8'hC0, 1'b1, 1'b0);
    wchk(`PIPU_OFS_RCTL, 8'h90, 1'b0, 1'b1);
    wchk(`PIPU_OFS_PPRI2, 8'h80, 1'b1, 1'b1);
    wchk(`PIPU_OFS_PEN1, 8'h00, 1'b1, 1'b0);
    wchk(`PIPU_OFS_PEN2, 8'h00, 1'b0, 1'b0);
    peer.drive(7'h00, 7'h00, 1'b0);
    fin("peripherals");
    wchk(`PIPU_OFS_CTL2, 8'h54, 1'b0, 1'b0);
    peer.pin(1, 1'b1);
    rd(`PIPU_OFS_CTL3, 8'h00, 8'h01);
    peer.pin(1, 1'b0);
    rd(`PIPU_OFS_CTL3, 8'h01, 8'h01);
    wchk(`PIPU_OFS_CTL3, 8'h00, 1'b0, 1'b0);
    wchk(`PIPU_OFS_CTL3, 8'h48, 1'b0, 1'b0);
    peer.pin(1, 1'b1);
    peer.pin(1, 1'b0);
    lv(1'b1, 1'b0);
    wchk(`PIPU_OFS_CTL3, 8'h41, 1'b0, 1'b0);
    wchk(`PIPU_OFS_CTL3, 8'h08, 1'b0, 1'b0);
    peer.pin(1, 1'b1);
    peer.pin(1, 1'b0);
    lv(1'b0, 1'b1);
    wchk(`PIPU_OFS_CTL3, 8'h00, 1'b0, 1'b0);
    wchk(`PIPU_OFS_CTL1, 8'hD0, 1'b0, 1'b0);
    peer.pin(0, 1'b1);
    lv(1'b1, 1'b0);
    wchk(`PIPU_OFS_CTL1, 8'hC0, 1'b0, 1'b0);
    fin("pins");
    wchk(`PIPU_OFS_CTL3, 8'h10, 1'b0, 1'b0);
    peer.drive(7'h00, 7'h00, 1'b1);
    wr(`PIPU_OFS_CTL1, 8'h40);
    peer.pin(2, 1'b1);
    lv(1'b0, 1'b0);
    chk(wake, 1'b1);
    chk(wake_br, 1'b0);
    wchk(`PIPU_OFS_CTL1, 8'hC0, 1'b0, 1'b1);
    chk(wake_br, 1'b1);
    peer.drive(7'h00, 7'h00, 1'b0);
    wchk(`PIPU_OFS_CTL3, 8'h00, 1'b0, 1'b0);
    chk(wake, 1'b0);
    fin("wake");
    wchk(`PIPU_OFS_CTL1, 8'hE0, 1'b0, 1'b0);
    wr(`PIPU_OFS_TCNT, 8'hFE);
    wchk(`PIPU_OFS_TCTL, 8'h01, 1'b1, 1'b0);
    wchk(`PIPU_OFS_CTL2, 8'h50, 1'b0, 1'b1);
    wchk(`PIPU_OFS_CTL1, 8'hC4, 1'b0, 1'b0);
    rd(`PIPU_OFS_CTL1, 8'h04, 8'h04);
    wr(`PIPU_OFS_TCTL, 8'h00);
    bus(1'b1, `PIPU_OFS_TCNT, 32'h0000_00FF, 4'h3);
    wr(`PIPU_OFS_CTL1, 8'hC0);
    wr(`PIPU_OFS_TCTL, 8'h03);
    rd(`PIPU_OFS_CTL1, 8'h00, 8'h04);
    wr(`PIPU_OFS_TCTL, 8'h00);
    bus(1'b1, `PIPU_OFS_TCNT, 32'h0000_FFFE, 4'h3);
    wr(`PIPU_OFS_TCTL, 8'h03);
    repeat (5) @(posedge clk);
    rd(`PIPU_OFS_CTL1, 8'h04, 8'h04);
    fin("timer");
    test_done();
  end
endmodule
`default_nettype wire

// ==== hw/pipu_map.svh ====
// register map, field positions and reset values of the interrupt priority unit
`ifndef PIPU_MAP_SVH
`define PIPU_MAP_SVH

`define PIPU_OFS_PEN1      6'h00
`define PIPU_OFS_PEN2      6'h04
`define PIPU_OFS_PPRI1     6'h08
`define PIPU_OFS_PPRI2     6'h0C
`define PIPU_OFS_RCTL      6'h10
`define PIPU_OFS_CTL1      6'h14
`define PIPU_OFS_CTL2      6'h18
`define PIPU_OFS_CTL3      6'h1C
`define PIPU_OFS_TCTL      6'h20
`define PIPU_OFS_TCNT      6'h24
`define PIPU_OFS_PFLG1     6'h28
`define PIPU_OFS_PFLG2     6'h2C

`define PIPU_PEN1_MASK     8'h7F
`define PIPU_PEN2_MASK     8'hFE
`define PIPU_PEN_RST       8'h00
`define PIPU_PPRI1_RST     8'h7F
`define PIPU_PPRI2_RST     8'hFE

`define PIPU_RCTL_PRIO     7
`define PIPU_RCTL_SBOR     6
`define PIPU_RCTL_RI       4
`define PIPU_RCTL_TO       3
`define PIPU_RCTL_PD       2
`define PIPU_RCTL_POR      1
`define PIPU_RCTL_BOR      0

`define PIPU_CTL1_GIE      7
`define PIPU_CTL1_PERIPHERAL_GROUP_ENABLE     6
`define PIPU_CTL1_T0E      5
`define PIPU_CTL1_X0E      4
`define PIPU_CTL1_T0F      2
`define PIPU_CTL1_X0F      1
`define PIPU_CTL2_MASK     8'h74
`define PIPU_CTL2_RST      8'h74
`define PIPU_CTL2_EDG0     6
`define PIPU_CTL2_T0P      2
`define PIPU_CTL3_MASK     8'hDB
`define PIPU_CTL3_RST      8'hC0
`define PIPU_CTL3_X2P      7
`define PIPU_CTL3_X1P      6
`define PIPU_CTL3_X2E      4
`define PIPU_CTL3_X1E      3
`define PIPU_CTL3_X2F      1
`define PIPU_CTL3_X1F      0
`define PIPU_TCTL_RUN      0
`define PIPU_TCTL_W16      1
`define PIPU_T8_MAX        8'hFF
`define PIPU_T16_MAX       16'hFFFF

`endif

// ==== hw/pipu_pkg.sv ====
// types shared by the interrupt priority unit
package pipu_pkg;
  typedef logic [7:0] pipu_byte_t;
  typedef enum logic [1:0] {
    PIPU_BOR_OFF,
    PIPU_BOR_SOFT,
    PIPU_BOR_RUN,
    PIPU_BOR_ALWAYS
  } pipu_bor_cfg_e;
endpackage

// ==== hw/pipu_top.sv ====
// interrupt enable, priority, pin and timer-zero logic with an avalon-mm register slave
`timescale 1ns/1ns
`default_nettype none
`include "pipu_map.svh"
module pipu_top
  import pipu_pkg::*;
(
  input  wire logic        clk_i,                  // core clock, 100 mhz
  input  wire logic        resetn_i,               // synchronous reset, low active
  input  wire logic [5:0]  avs_address_i,          // byte address
  input  wire logic        avs_read_i,             // read request
  input  wire logic        avs_write_i,            // write request
  input  wire logic [31:0] avs_writedata_i,        // write data
  input  wire logic [3:0]  avs_byteenable_i,       // byte lanes
  output logic      [31:0] avs_readdata_o,         // read data
  output logic             avs_waitrequest_o,      // stall
  input  wire logic [6:0]  periph_flags_one_i,     // first group flags
  input  wire logic [7:1]  periph_flags_two_i,     // second group flags
  input  wire logic        ext_irq_zero_i,         // pin zero
  input  wire logic        ext_irq_one_i,          // pin one
  input  wire logic        ext_irq_two_i,          // pin two
  input  wire logic        low_power_i,            // core in idle or sleep
  input  wire logic        reset_instr_i,          // reset instruction executed
  input  wire logic        timeout_flag_i,         // watchdog status level
  input  wire logic        powerdown_flag_i,       // power-down status level
  input  wire logic [1:0]  brownout_config_field_i,// static configuration
  output logic             irq_high_o,             // high priority request
  output logic             irq_low_o,              // low priority request
  output logic             wake_o,                 // wake the core
  output logic             wake_branch_o,          // wake and take vector
  output logic             soft_brownout_enable_o  // brown-out enable level
);

  // register state
  pipu_byte_t  pen1_r, pen2_r, ppri1_r, ppri2_r, ctl2_r, ctl3_r;
  logic        prio_mode_r, sbor_r, ri_r, por_r, bor_r;
  logic        gie_r, peripheral_group_enable_r, t0e_r, x0e_r, t0f_r, x0f_r;
  logic        trun_r, t16_r;
  logic [15:0] tcnt_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [2:0]  sync1_r, sync2_r, prev_r;
  logic        irq_high_r, irq_low_r, wake_r, wake_br_r;
  logic        armed_r;

  // bus decode
  wire        req      = avs_read_i | avs_write_i;
  wire        wr_en    = avs_write_i & ~wait_r & avs_byteenable_i[0];
  wire        wr_hi    = avs_write_i & ~wait_r & avs_byteenable_i[1];
  wire [7:0]  wd       = avs_writedata_i[7:0];
  wire        wr_pen1  = wr_en & (avs_address_i == `PIPU_OFS_PEN1);
  wire        wr_pen2  = wr_en & (avs_address_i == `PIPU_OFS_PEN2);
  wire        wr_ppri1 = wr_en & (avs_address_i == `PIPU_OFS_PPRI1);
  wire        wr_ppri2 = wr_en & (avs_address_i == `PIPU_OFS_PPRI2);
  wire        wr_rctl  = wr_en & (avs_address_i == `PIPU_OFS_RCTL);
  wire        wr_ctl1  = wr_en & (avs_address_i == `PIPU_OFS_CTL1);
  wire        wr_ctl2  = wr_en & (avs_address_i == `PIPU_OFS_CTL2);
  wire        wr_ctl3  = wr_en & (avs_address_i == `PIPU_OFS_CTL3);
  wire        wr_tctl  = wr_en & (avs_address_i == `PIPU_OFS_TCTL);
  wire        wr_tlo   = wr_en & (avs_address_i == `PIPU_OFS_TCNT);
  wire        wr_thi   = wr_hi & (avs_address_i == `PIPU_OFS_TCNT);

  // brown-out configuration decode
  wire        bor_soft = (pipu_bor_cfg_e'(brownout_config_field_i) == PIPU_BOR_SOFT);

  // read views, unimplemented positions forced to zero
  wire [7:0]  rctl_v = {prio_mode_r, sbor_r & bor_soft, 1'b0, ri_r,
                        timeout_flag_i, powerdown_flag_i, por_r, bor_r};
  wire [7:0]  ctl1_v = {gie_r, peripheral_group_enable_r, t0e_r, x0e_r, 1'b0, t0f_r, x0f_r, 1'b0};

  // read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (avs_address_i)
      `PIPU_OFS_PEN1:  rmux[7:0] = pen1_r;
      `PIPU_OFS_PEN2:  rmux[7:0] = pen2_r;
      `PIPU_OFS_PPRI1: rmux[7:0] = ppri1_r;
      `PIPU_OFS_PPRI2: rmux[7:0] = ppri2_r;
      `PIPU_OFS_RCTL:  rmux[7:0] = rctl_v;
      `PIPU_OFS_CTL1:  rmux[7:0] = ctl1_v;
      `PIPU_OFS_CTL2:  rmux[7:0] = ctl2_r;
      `PIPU_OFS_CTL3:  rmux[7:0] = ctl3_r;
      `PIPU_OFS_TCTL:  rmux[7:0] = {6'h00, t16_r, trun_r};
      `PIPU_OFS_TCNT:  rmux[15:0] = tcnt_r;
      `PIPU_OFS_PFLG1: rmux[7:0] = {1'b0, periph_flags_one_i};
      `PIPU_OFS_PFLG2: rmux[7:0] = {periph_flags_two_i, 1'b0};
      default:         rmux = 32'h0000_0000;
    endcase
  end

  // one wait state: request seen, then answered with waitrequest low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) begin
        rdata_r <= rmux;
      end
    end
  end

  // peripheral enable and priority registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pen1_r  <= `PIPU_PEN_RST;
      pen2_r  <= `PIPU_PEN_RST;
      ppri1_r <= `PIPU_PPRI1_RST;
      ppri2_r <= `PIPU_PPRI2_RST;
    end else begin
      if (wr_pen1)  pen1_r  <= wd & `PIPU_PEN1_MASK;
      if (wr_pen2)  pen2_r  <= wd & `PIPU_PEN2_MASK;
      if (wr_ppri1) ppri1_r <= wd & `PIPU_PEN1_MASK;
      if (wr_ppri2) ppri2_r <= wd & `PIPU_PEN2_MASK;
    end
  end

  // reset-control register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prio_mode_r <= 1'b0;
      sbor_r      <= bor_soft;
      ri_r        <= 1'b1;
      por_r       <= 1'b0;
      bor_r       <= 1'b0;
    end else begin
      if (wr_rctl) begin
        prio_mode_r <= wd[`PIPU_RCTL_PRIO];
        sbor_r      <= wd[`PIPU_RCTL_SBOR] & bor_soft;
        por_r       <= wd[`PIPU_RCTL_POR];
        bor_r       <= wd[`PIPU_RCTL_BOR];
      end
      if (reset_instr_i) begin
        ri_r <= 1'b0;
      end else if (wr_rctl) begin
        ri_r <= wd[`PIPU_RCTL_RI];
      end
    end
  end

  // external pin synchronisers and edge detect
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
    end else begin
      sync1_r <= {ext_irq_two_i, ext_irq_one_i, ext_irq_zero_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  wire [2:0] edge_sel = ctl2_r[`PIPU_CTL2_EDG0 -: 3] == 3'h0 ? 3'h0 :
                        {ctl2_r[`PIPU_CTL2_EDG0-2], ctl2_r[`PIPU_CTL2_EDG0-1], ctl2_r[`PIPU_CTL2_EDG0]};
  wire [2:0] rise     = sync2_r & ~prev_r;
  wire [2:0] fall     = ~sync2_r & prev_r;
  wire [2:0] pin_hit  = (rise & edge_sel) | (fall & ~edge_sel);

  // timer zero
  wire        t8_wrap  = trun_r & ~t16_r & (tcnt_r[7:0] == `PIPU_T8_MAX);
  wire        t16_wrap = trun_r & t16_r & (tcnt_r == `PIPU_T16_MAX);
  wire        t0_hit   = t8_wrap | t16_wrap;
  wire [15:0] tinc     = tcnt_r + 16'h0001;
  wire [15:0] tnext    = t16_r ? tinc : {tcnt_r[15:8], tinc[7:0]};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trun_r <= 1'b0;
      t16_r  <= 1'b0;
      tcnt_r <= 16'h0000;
    end else begin
      if (wr_tctl) begin
        trun_r <= wd[`PIPU_TCTL_RUN];
        t16_r  <= wd[`PIPU_TCTL_W16];
      end
      if (wr_tlo | wr_thi) begin
        tcnt_r <= {wr_thi ? avs_writedata_i[15:8] : tcnt_r[15:8], wr_tlo ? wd : tcnt_r[7:0]};
      end else if (trun_r) begin
        tcnt_r <= tnext;
      end
    end
  end

  // control one: global, group and source bits; hardware set beats software clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gie_r  <= 1'b0;
      peripheral_group_enable_r <= 1'b0;
      t0e_r  <= 1'b0;
      x0e_r  <= 1'b0;
      t0f_r  <= 1'b0;
      x0f_r  <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        gie_r  <= wd[`PIPU_CTL1_GIE];
        peripheral_group_enable_r <= wd[`PIPU_CTL1_PERIPHERAL_GROUP_ENABLE];
        t0e_r  <= wd[`PIPU_CTL1_T0E];
        x0e_r  <= wd[`PIPU_CTL1_X0E];
      end
      t0f_r <= t0_hit | (wr_ctl1 ? wd[`PIPU_CTL1_T0F] : t0f_r);
      x0f_r <= pin_hit[0] | (wr_ctl1 ? wd[`PIPU_CTL1_X0F] : x0f_r);
    end
  end

  // control two and three
  wire [7:0] ctl3_w = wd & `PIPU_CTL3_MASK;
  wire [7:0] ctl3_f = wr_ctl3 ? ctl3_w : ctl3_r;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctl2_r <= `PIPU_CTL2_RST;
      ctl3_r <= `PIPU_CTL3_RST;
    end else begin
      if (wr_ctl2) ctl2_r <= wd & `PIPU_CTL2_MASK;
      ctl3_r <= {ctl3_f[7:2],
                 ctl3_f[`PIPU_CTL3_X2F] | pin_hit[2],
                 ctl3_f[`PIPU_CTL3_X1F] | pin_hit[1]};
    end
  end

  // pending sources, flag and enable both set
  wire [6:0] p1_pend = periph_flags_one_i & pen1_r[6:0];
  wire [7:1] p2_pend = periph_flags_two_i & pen2_r[7:1];
  wire       t0_pend = t0f_r & t0e_r;
  wire       x0_pend = x0f_r & x0e_r;
  wire       x1_pend = ctl3_r[`PIPU_CTL3_X1F] & ctl3_r[`PIPU_CTL3_X1E];
  wire       x2_pend = ctl3_r[`PIPU_CTL3_X2F] & ctl3_r[`PIPU_CTL3_X2E];

  // priority routing
  wire       per_any  = (|p1_pend) | (|p2_pend);
  wire       per_hi   = (|(p1_pend & ppri1_r[6:0])) | (|(p2_pend & ppri2_r[7:1]));
  wire       per_lo   = (|(p1_pend & ~ppri1_r[6:0])) | (|(p2_pend & ~ppri2_r[7:1]));
  wire       t0_hi    = t0_pend & ctl2_r[`PIPU_CTL2_T0P];
  wire       t0_lo    = t0_pend & ~ctl2_r[`PIPU_CTL2_T0P];
  wire       x1_hi    = x1_pend & ctl3_r[`PIPU_CTL3_X1P];
  wire       x2_hi    = x2_pend & ctl3_r[`PIPU_CTL3_X2P];
  wire       x12_lo   = (x1_pend & ~ctl3_r[`PIPU_CTL3_X1P]) | (x2_pend & ~ctl3_r[`PIPU_CTL3_X2P]);
  wire       core_any = t0_pend | x0_pend | x1_pend | x2_pend;
  wire       any_hi   = x0_pend | x1_hi | x2_hi | t0_hi | per_hi;
  wire       any_lo   = x12_lo | t0_lo | per_lo;
  wire       legacy_q = gie_r & (core_any | (peripheral_group_enable_r & per_any));
  wire       high_nxt = prio_mode_r ? (gie_r & any_hi) : legacy_q;
  wire       low_nxt  = prio_mode_r & gie_r & peripheral_group_enable_r & any_lo;

  // wake-up: enables must be armed before entering low power
  wire       pin_en   = x0e_r | ctl3_r[`PIPU_CTL3_X1E] | ctl3_r[`PIPU_CTL3_X2E];
  wire       pin_pend = x0_pend | x1_pend | x2_pend;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_high_r <= 1'b0;
      irq_low_r  <= 1'b0;
      armed_r    <= 1'b0;
      wake_r     <= 1'b0;
      wake_br_r  <= 1'b0;
    end else begin
      irq_high_r <= high_nxt;
      irq_low_r  <= low_nxt;
      armed_r    <= low_power_i ? armed_r : pin_en;
      wake_r     <= low_power_i & armed_r & pin_pend;
      wake_br_r  <= low_power_i & armed_r & pin_pend & gie_r;
    end
  end

  assign avs_readdata_o         = rdata_r;
  assign avs_waitrequest_o      = wait_r;
  assign irq_high_o             = irq_high_r;
  assign irq_low_o              = irq_low_r;
  assign wake_o                 = wake_r;
  assign wake_branch_o          = wake_br_r;
  assign soft_brownout_enable_o = sbor_r;

  // checks
  a_legacy_group_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!prio_mode_r && !peripheral_group_enable_r && !core_any) |=> !irq_high_o)
    else $error("peripheral request passed without group enable");
  a_legacy_no_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !prio_mode_r |=> !irq_low_o)
    else $error("low request in legacy mode");
  a_pen1_bit7_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !pen1_r[7] && !pen2_r[0] && !ppri1_r[7] && !ppri2_r[0])
    else $error("unimplemented enable or priority bit set");
  a_ri_cleared: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reset_instr_i |=> !ri_r)
    else $error("reset instruction flag not cleared");
  a_sbor_cfg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !bor_soft |-> !rctl_v[`PIPU_RCTL_SBOR])
    else $error("brown-out enable visible outside soft config");
  a_edge_sets_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pin_hit[0] |=> x0f_r)
    else $error("pin zero edge lost");
  a_zero_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (prio_mode_r && gie_r && x0_pend) |=> irq_high_o)
    else $error("pin zero not high priority");
  a_t8_wrap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (t8_wrap && !wr_tlo && !wr_thi) |=> (tcnt_r[7:0] == 8'h00) && t0f_r)
    else $error("8-bit wrap did not set overflow");
  a_t16_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (t16_r && trun_r && tcnt_r != 16'hFFFF) |-> !t0_hit)
    else $error("16-bit overflow early");
  a_wake_branch: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_branch_o |-> wake_o && $past(gie_r))
    else $error("branch without global enable");
endmodule
`default_nettype wire
